/* src/pcl_config_regs.sv */
// configuration and limit register bank of a multi-phase buck converter
//
// Overview of operation
// R01: feature bit 7 reports crc check support
// R02: feature bits 6:5 report maximum bus speed
// R03: feature bit 4 reports alert pin support
// R04: feature bit 3 reports numeric format kind
// R05: feature bit 2 reports adaptive bus; 1:0 reserved
// R06: reserved bits ignore writes, read zero
// R07: phase count held; shed until running equals it
// R08: phase count never saved to non-volatile store
// R09: format bits 6:5 select linear, vid, direct
// R10: format parameter forced by selected mode
// R11: twelve-bit setpoint defines the override reference
// R12: upper and lower limit words bound reference
// R13: margin words supply reference when selected
// R14: divider ratio field holds ratio times 1024
// R15: coefficient block read returns five bytes
// R16: lockout thresholds are seven-bit fields
// R17: current gain fixed at 1024, scales report
// R18: signed offset added to reported current
// R19: over-current fault limit ten bits
// R20: over-current warning limit ten bits
// R21: boot entry applies only under address conditions
// R22: over-temperature limits are eight-bit fields
// R23: source select picks setpoint, low or high
// R24: writes to read-only commands change nothing
`timescale 1ns/10ps
`default_nettype none
module pcl_config_regs
  import pcl_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RSTN,
  // command port
  input  wire logic        I_REQ_VALID,
  input  wire logic        I_REQ_WRITE,
  input  wire logic [7:0]  I_REQ_CODE,
  input  wire logic [15:0] I_REQ_DATA,
  output logic             O_ACK,
  output logic             O_NACK,
  output logic [39:0]      O_RD_DATA,
  output logic [2:0]       O_RD_LEN,
  // reference
  input  wire logic [1:0]  I_REF_SOURCE,
  output logic [11:0]      O_VREF_CODE,
  output logic             O_VREF_CLAMPED,
  output logic             O_FMT_LINEAR,
  // phases
  input  wire logic [5:0]  I_ACTIVE_PHASES,
  output logic [5:0]       O_PHASE_TARGET,
  output logic             O_PHASE_SHED,
  // limits
  output logic [10:0]      O_DIVIDER_RATIO,
  output logic [6:0]       O_LOCKOUT_RISE,
  output logic [6:0]       O_LOCKOUT_FALL,
  output logic [9:0]       O_OC_FAULT_LIMIT,
  output logic [9:0]       O_OC_WARN_LIMIT,
  output logic [7:0]       O_OVERTEMP_FAULT_LIMIT,
  output logic [7:0]       O_OVERTEMP_WARN_LIMIT,
  // current report
  input  wire logic [15:0] I_IOUT_RAW,
  output logic [15:0]      O_IOUT_REPORT,
  // boot voltage
  input  wire logic [3:0]  I_BUS_ADDR_LOW,
  input  wire logic        I_ADDR_CFG_BIT7,
  input  wire logic        I_CFG_BIT4,
  output logic [9:0]       O_VBOOT_CODE,
  output logic             O_VBOOT_ACTIVE,
  // non-volatile save
  input  wire logic        I_STORE_ALL,
  output logic             O_NVM_BUSY,
  output logic             O_NVM_WR_VALID,
  output logic [7:0]       O_NVM_WR_CODE,
  output logic [15:0]      O_NVM_WR_DATA
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [5:0]            phase_shed_count_r;
  logic [1:0]            fmt_mode_r;
  logic                  fmt_linear_r;
  logic [11:0]           vout_setpoint_r;
  logic [11:0]           vout_upper_limit_r;
  logic [11:0]           vout_margin_upper_r;
  logic [11:0]           vout_margin_lower_r;
  logic [10:0]           divider_ratio_r;
  logic [11:0]           vout_lower_limit_r;
  logic [6:0]            lockout_rise_r;
  logic [6:0]            lockout_fall_r;
  logic [8:0]            current_offset_r;
  logic [9:0]            oc_fault_r;
  logic [9:0]            oc_warn_r;
  logic [9:0]            boot_group0_r;
  logic [7:0]            ot_fault_r;
  logic [7:0]            ot_warn_r;
  logic                  ack_r;
  logic                  nack_r;
  logic [39:0]           rd_data_r;
  logic [2:0]            rd_len_r;
  logic [11:0]           vref_r;
  logic                  clamped_r;
  logic                  phase_shed_r;
  logic [15:0]           iout_r;
  logic [9:0]            vboot_r;
  logic                  vboot_active_r;
  pcl_save_state_t       save_state_r;
  logic [3:0]            save_idx_r;
  logic                  nvm_busy_r;
  logic                  nvm_valid_r;
  logic [7:0]            nvm_code_r;
  logic [15:0]           nvm_data_r;
  logic                  req_ok;
  logic                  wr_ok;
  logic [11:0]           vref_sel;
  logic [11:0]           vref_nxt;
  logic                  clamped_nxt;
  logic signed [27:0]    iout_prod;
  logic signed [27:0]    iout_sum;
  logic                  boot_ok;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic [2:0] cmd_len(input logic [7:0] c);
    case (c)
      CMD_FEATURE, CMD_PHASE_SHED, CMD_VOUT_FORMAT: cmd_len = LEN_BYTE;
      CMD_COEFFS: cmd_len = LEN_BLOCK;
      CMD_SETPOINT, CMD_UPPER_LIM, CMD_MARGIN_UP, CMD_MARGIN_LO, CMD_DIV_RATIO,
      CMD_LOWER_LIM, CMD_LOCK_RISE, CMD_LOCK_FALL, CMD_GAIN, CMD_OFFSET,
      CMD_OC_FAULT, CMD_OC_WARN, CMD_BOOT_GRP0, CMD_OT_FAULT, CMD_OT_WARN:
        cmd_len = LEN_WORD;
      default: cmd_len = LEN_NONE;
    endcase
  endfunction

  function automatic logic is_read_only(input logic [7:0] c);
    is_read_only = (c == CMD_FEATURE) || (c == CMD_COEFFS);
  endfunction

  function automatic logic [4:0] fmt_param(input logic [1:0] m);
    fmt_param = (m == FMT_LINEAR) ? FMT_EXP_LINEAR : FMT_EXP_OTHER; // [R10]
  endfunction

  // read image of a command; unused upper bits stay zero
  function automatic logic [39:0] rd_value(input logic [7:0] c);
    logic [39:0] v;
    v = '0; // [R06]
    case (c)
      CMD_FEATURE:     v[7:0]  = CAP_BYTE; // [R01] [R02] [R03] [R04] [R05]
      CMD_PHASE_SHED:  v[5:0]  = phase_shed_count_r;
      CMD_VOUT_FORMAT: v[6:0]  = {fmt_mode_r, fmt_param(fmt_mode_r)}; // [R09] [R10]
      CMD_SETPOINT:    v[11:0] = vout_setpoint_r;
      CMD_UPPER_LIM:   v[11:0] = vout_upper_limit_r;
      CMD_MARGIN_UP:   v[11:0] = vout_margin_upper_r;
      CMD_MARGIN_LO:   v[11:0] = vout_margin_lower_r;
      CMD_DIV_RATIO:   v[10:0] = divider_ratio_r;
      CMD_LOWER_LIM:   v[11:0] = vout_lower_limit_r;
      CMD_COEFFS:      v       = COEF_BLOCK; // [R15]
      CMD_LOCK_RISE:   v[6:0]  = lockout_rise_r;
      CMD_LOCK_FALL:   v[6:0]  = lockout_fall_r;
      CMD_GAIN:        v[10:0] = GAIN_FIXED; // [R17]
      CMD_OFFSET:      v[8:0]  = current_offset_r;
      CMD_OC_FAULT:    v[9:0]  = oc_fault_r;
      CMD_OC_WARN:     v[9:0]  = oc_warn_r;
      CMD_BOOT_GRP0:   v[9:0]  = boot_group0_r;
      CMD_OT_FAULT:    v[7:0]  = ot_fault_r;
      CMD_OT_WARN:     v[7:0]  = ot_warn_r;
      default:         v       = '0;
    endcase
    return v;
  endfunction

  // commands walked by a save; the phase count is left out
  function automatic logic [7:0] save_code(input logic [3:0] i);
    unique case (i)
      4'h0: save_code = CMD_VOUT_FORMAT;
      4'h1: save_code = CMD_SETPOINT;
      4'h2: save_code = CMD_UPPER_LIM;
      4'h3: save_code = CMD_MARGIN_UP;
      4'h4: save_code = CMD_MARGIN_LO;
      4'h5: save_code = CMD_DIV_RATIO;
      4'h6: save_code = CMD_LOWER_LIM;
      4'h7: save_code = CMD_LOCK_RISE;
      4'h8: save_code = CMD_LOCK_FALL;
      4'h9: save_code = CMD_GAIN;
      4'hA: save_code = CMD_OFFSET;
      4'hB: save_code = CMD_OC_FAULT;
      4'hC: save_code = CMD_OC_WARN;
      4'hD: save_code = CMD_BOOT_GRP0;
      4'hE: save_code = CMD_OT_FAULT;
      4'hF: save_code = CMD_OT_WARN;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  assign req_ok = I_REQ_VALID && (cmd_len(I_REQ_CODE) != LEN_NONE)
                  && !(I_REQ_WRITE && is_read_only(I_REQ_CODE)); // [R24]
  assign wr_ok  = req_ok && I_REQ_WRITE;

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      phase_shed_count_r  <= RST_PHASES;
      fmt_mode_r          <= RST_FMT;
      fmt_linear_r        <= (RST_FMT == FMT_LINEAR);
      vout_setpoint_r     <= RST_VOUT;
      vout_upper_limit_r  <= RST_VOUT_UPPER_LIMIT;
      vout_margin_upper_r <= RST_VOUT;
      vout_margin_lower_r <= RST_VOUT;
      divider_ratio_r     <= RST_DIV;
      vout_lower_limit_r  <= RST_VOUT;
      lockout_rise_r      <= RST_LOCK;
      lockout_fall_r      <= RST_LOCK;
      current_offset_r    <= RST_OFFSET;
      oc_fault_r          <= RST_OC;
      oc_warn_r           <= RST_OC;
      boot_group0_r       <= RST_BOOT;
      ot_fault_r          <= RST_OT;
      ot_warn_r           <= RST_OT;
    end else if (wr_ok) begin
      // only the defined field of each word is kept
      case (I_REQ_CODE) // [R06]
        CMD_PHASE_SHED:  phase_shed_count_r  <= I_REQ_DATA[5:0]; // [R07]
        CMD_VOUT_FORMAT: begin
          fmt_mode_r   <= I_REQ_DATA[6:5]; // [R09]
          fmt_linear_r <= (I_REQ_DATA[6:5] == FMT_LINEAR); // [R09]
        end
        CMD_SETPOINT:    vout_setpoint_r     <= I_REQ_DATA[11:0]; // [R11]
        CMD_UPPER_LIM:   vout_upper_limit_r  <= I_REQ_DATA[11:0]; // [R12]
        CMD_MARGIN_UP:   vout_margin_upper_r <= I_REQ_DATA[11:0]; // [R13]
        CMD_MARGIN_LO:   vout_margin_lower_r <= I_REQ_DATA[11:0]; // [R13]
        CMD_DIV_RATIO:   divider_ratio_r     <= I_REQ_DATA[10:0]; // [R14]
        CMD_LOWER_LIM:   vout_lower_limit_r  <= I_REQ_DATA[11:0]; // [R12]
        CMD_LOCK_RISE:   lockout_rise_r      <= I_REQ_DATA[6:0]; // [R16]
        CMD_LOCK_FALL:   lockout_fall_r      <= I_REQ_DATA[6:0]; // [R16]
        CMD_OFFSET:      current_offset_r    <= I_REQ_DATA[8:0]; // [R18]
        CMD_OC_FAULT:    oc_fault_r          <= I_REQ_DATA[9:0]; // [R19]
        CMD_OC_WARN:     oc_warn_r           <= I_REQ_DATA[9:0]; // [R20]
        CMD_BOOT_GRP0:   boot_group0_r       <= I_REQ_DATA[9:0]; // [R21]
        CMD_OT_FAULT:    ot_fault_r          <= I_REQ_DATA[7:0]; // [R22]
        CMD_OT_WARN:     ot_warn_r           <= I_REQ_DATA[7:0]; // [R22]
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command answer, one cycle after the request
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ack_r     <= 1'b0;
      nack_r    <= 1'b0;
      rd_data_r <= '0;
      rd_len_r  <= LEN_NONE;
    end else begin
      ack_r  <= req_ok;
      nack_r <= I_REQ_VALID && !req_ok; // [R24]
      if (I_REQ_VALID && !I_REQ_WRITE) begin
        rd_data_r <= rd_value(I_REQ_CODE);
        rd_len_r  <= cmd_len(I_REQ_CODE);
      end else begin
        rd_data_r <= '0;
        rd_len_r  <= LEN_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference selection and bounding
  always_comb begin
    vref_sel = vref_r;
    unique case (I_REF_SOURCE) // [R23]
      SRC_SETPOINT:  vref_sel = vout_setpoint_r; // [R11]
      SRC_MARGIN_LO: vref_sel = vout_margin_lower_r; // [R13]
      SRC_MARGIN_HI: vref_sel = vout_margin_upper_r; // [R13]
      default:       vref_sel = vref_r;
    endcase
    clamped_nxt = 1'b1;
    if (vref_sel > vout_upper_limit_r) begin // [R12]
      vref_nxt = vout_upper_limit_r;
    end else if (vref_sel < vout_lower_limit_r) begin
      vref_nxt = vout_lower_limit_r;
    end else begin
      vref_nxt    = vref_sel;
      clamped_nxt = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      vref_r    <= RST_VOUT;
      clamped_r <= 1'b0;
    end else begin
      vref_r    <= vref_nxt;
      clamped_r <= clamped_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase shedding request
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      phase_shed_r <= 1'b0;
    end else begin
      phase_shed_r <= I_ACTIVE_PHASES > phase_shed_count_r; // [R07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current report: raw times gain over 1024 plus signed offset
  assign iout_prod = $signed(I_IOUT_RAW) * $signed({1'b0, GAIN_FIXED}); // [R17]
  assign iout_sum  = (iout_prod >>> GAIN_SHIFT)
                     + $signed({{19{current_offset_r[8]}}, current_offset_r}); // [R18]

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      iout_r <= '0;
    end else begin
      iout_r <= iout_sum[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot voltage for the lowest address group
  assign boot_ok = !I_ADDR_CFG_BIT7 && I_CFG_BIT4 && (I_BUS_ADDR_LOW <= BOOT_ADDR_LAST);

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      vboot_r        <= '0;
      vboot_active_r <= 1'b0;
    end else begin
      vboot_active_r <= boot_ok; // [R21]
      vboot_r        <= boot_ok ? boot_group0_r : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // save walk: one word per cycle, sixteen words
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      save_state_r <= PCL_IDLE;
      save_idx_r   <= '0;
      nvm_busy_r   <= 1'b0;
      nvm_valid_r  <= 1'b0;
      nvm_code_r   <= '0;
      nvm_data_r   <= '0;
    end else begin
      nvm_valid_r <= 1'b0;
      unique case (save_state_r)
        PCL_IDLE: begin
          save_idx_r <= '0;
          if (I_STORE_ALL) begin
            save_state_r <= PCL_SAVE;
            nvm_busy_r   <= 1'b1;
          end
        end
        PCL_SAVE: begin
          nvm_valid_r <= 1'b1;
          nvm_code_r  <= save_code(save_idx_r); // [R08]
          nvm_data_r  <= 16'(rd_value(save_code(save_idx_r)));
          save_idx_r  <= save_idx_r + 4'h1;
          if (save_idx_r == SAVE_LAST) begin
            save_state_r <= PCL_IDLE;
            nvm_busy_r   <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign O_ACK            = ack_r;
  assign O_NACK           = nack_r;
  assign O_RD_DATA        = rd_data_r;
  assign O_RD_LEN         = rd_len_r;
  assign O_VREF_CODE      = vref_r;
  assign O_VREF_CLAMPED   = clamped_r;
  assign O_FMT_LINEAR     = fmt_linear_r;
  assign O_PHASE_TARGET   = phase_shed_count_r;
  assign O_PHASE_SHED     = phase_shed_r;
  assign O_DIVIDER_RATIO  = divider_ratio_r;
  assign O_LOCKOUT_RISE   = lockout_rise_r;
  assign O_LOCKOUT_FALL   = lockout_fall_r;
  assign O_OC_FAULT_LIMIT = oc_fault_r;
  assign O_OC_WARN_LIMIT  = oc_warn_r;
  assign O_OVERTEMP_FAULT_LIMIT = ot_fault_r;
  assign O_OVERTEMP_WARN_LIMIT  = ot_warn_r;
  assign O_IOUT_REPORT    = iout_r;
  assign O_VBOOT_CODE     = vboot_r;
  assign O_VBOOT_ACTIVE   = vboot_active_r;
  assign O_NVM_BUSY       = nvm_busy_r;
  assign O_NVM_WR_VALID   = nvm_valid_r;
  assign O_NVM_WR_CODE    = nvm_code_r;
  assign O_NVM_WR_DATA    = nvm_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  sequence rd_req(logic [7:0] c);
    I_REQ_VALID && !I_REQ_WRITE && I_REQ_CODE == c;
  endsequence

  sequence save_burst;
    O_NVM_WR_VALID [*8];
  endsequence

  crc_bit_a: assert property (rd_req(CMD_FEATURE) // [R01]
                              |=> O_ACK && O_RD_DATA[7] == CAP_CRC_CHECK)
    else $error("crc support bit wrong");
  bus_speed_a: assert property (rd_req(CMD_FEATURE) |=> O_RD_DATA[6:5] == CAP_BUS_SPEED) // [R02]
    else $error("bus speed field wrong");
  alert_bit_a: assert property (rd_req(CMD_FEATURE) |=> O_RD_DATA[4] == CAP_ALERT_PIN) // [R03]
    else $error("alert support bit wrong");
  num_fmt_a: assert property (rd_req(CMD_FEATURE) |=> O_RD_DATA[3] == CAP_NUM_FMT) // [R04]
    else $error("numeric format bit wrong");
  feat_low_a: assert property (rd_req(CMD_FEATURE) // [R05]
                               |=> O_RD_DATA[2:0] == {CAP_AVS_BUS, 2'h0})
    else $error("feature low bits wrong");
  resvd_zero_a: assert property (rd_req(CMD_SETPOINT) |=> O_RD_DATA[39:12] == '0) // [R06]
    else $error("reserved bits not zero");
  phase_shed_a: assert property ((I_ACTIVE_PHASES > O_PHASE_TARGET) |=> O_PHASE_SHED) // [R07]
    else $error("shed request missing");
  save_skip_a: assert property (O_NVM_WR_VALID |-> O_NVM_WR_CODE != CMD_PHASE_SHED) // [R08]
    else $error("phase count saved");
  save_run_a: assert property (I_STORE_ALL && !O_NVM_BUSY |=> O_NVM_BUSY ##1 save_burst) // [R08]
    else $error("save walk broken");
  fmt_param_a: assert property (rd_req(CMD_VOUT_FORMAT) && fmt_mode_r == FMT_LINEAR // [R10]
                                |=> O_RD_DATA[4:0] == FMT_EXP_LINEAR)
    else $error("linear exponent wrong");
  ref_bound_a: assert property (vout_lower_limit_r <= vout_upper_limit_r // [R12]
                                |=> O_VREF_CODE <= $past(vout_upper_limit_r))
    else $error("reference above upper limit");
  margin_lo_a: assert property (I_REF_SOURCE == SRC_MARGIN_LO // [R23]
                                && vout_margin_lower_r >= vout_lower_limit_r
                                && vout_margin_lower_r <= vout_upper_limit_r
                                |=> O_VREF_CODE == $past(vout_margin_lower_r))
    else $error("margin low not selected");
  coef_read_a: assert property (rd_req(CMD_COEFFS) |=> O_RD_DATA == COEF_BLOCK // [R15]
                                && O_RD_LEN == LEN_BLOCK)
    else $error("coefficient block wrong");
  gain_read_a: assert property (rd_req(CMD_GAIN) |=> O_RD_DATA[15:0] == 16'h0400) // [R17]
    else $error("gain not fixed");
  boot_gate_a: assert property (O_VBOOT_ACTIVE // [R21]
                                |-> !$past(I_ADDR_CFG_BIT7) && $past(I_CFG_BIT4))
    else $error("boot entry ungated");
  ro_write_a: assert property (I_REQ_VALID && I_REQ_WRITE && I_REQ_CODE == CMD_COEFFS // [R24]
                               |=> O_NACK && !O_ACK)
    else $error("read-only write accepted");

endmodule
`default_nettype wire

/* src/pcl_pkg.sv */
// constants for the configuration and limit register bank
package pcl_pkg;
  // command codes
  localparam logic [7:0] CMD_FEATURE     = 8'h19;
  localparam logic [7:0] CMD_PHASE_SHED  = 8'h1C;
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
  localparam logic [7:0] CMD_SETPOINT    = 8'h21;
  localparam logic [7:0] CMD_UPPER_LIM   = 8'h24;
  localparam logic [7:0] CMD_MARGIN_UP   = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO   = 8'h26;
  localparam logic [7:0] CMD_DIV_RATIO   = 8'h29;
  localparam logic [7:0] CMD_LOWER_LIM   = 8'h2B;
  localparam logic [7:0] CMD_COEFFS      = 8'h30;
  localparam logic [7:0] CMD_LOCK_RISE   = 8'h35;
  localparam logic [7:0] CMD_LOCK_FALL   = 8'h36;
  localparam logic [7:0] CMD_GAIN        = 8'h38;
  localparam logic [7:0] CMD_OFFSET      = 8'h39;
  localparam logic [7:0] CMD_OC_FAULT    = 8'h46;
  localparam logic [7:0] CMD_OC_WARN     = 8'h4A;
  localparam logic [7:0] CMD_BOOT_GRP0   = 8'h4D;
  localparam logic [7:0] CMD_OT_FAULT    = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN     = 8'h51;
  // feature byte content
  localparam logic [1:0] SPEED_100K      = 2'h0;
  localparam logic [1:0] SPEED_400K      = 2'h1;
  localparam logic [1:0] SPEED_1M        = 2'h2;
  localparam logic       CAP_CRC_CHECK   = 1'h1;
  localparam logic [1:0] CAP_BUS_SPEED   = SPEED_400K;
  localparam logic       CAP_ALERT_PIN   = 1'h1;
  localparam logic       CAP_NUM_FMT     = 1'h0;
  localparam logic       CAP_AVS_BUS     = 1'h0;
  localparam logic [7:0] CAP_BYTE        = {CAP_CRC_CHECK, CAP_BUS_SPEED, CAP_ALERT_PIN,
                                            CAP_NUM_FMT, CAP_AVS_BUS, 2'h0};
  // output voltage format
  localparam logic [1:0] FMT_LINEAR      = 2'h0;
  localparam logic [1:0] FMT_VID         = 2'h1;
  localparam logic [4:0] FMT_EXP_LINEAR  = 5'h17;
  localparam logic [4:0] FMT_EXP_OTHER   = 5'h00;
  // reference source select
  localparam logic [1:0] SRC_SETPOINT    = 2'h0;
  localparam logic [1:0] SRC_MARGIN_LO   = 2'h1;
  localparam logic [1:0] SRC_MARGIN_HI   = 2'h2;
  // fixed values
  localparam logic [39:0] COEF_BLOCK     = 40'h01_0000_0040;
  localparam logic [10:0] GAIN_FIXED     = 11'h400;
  localparam int          GAIN_SHIFT     = 10;
  localparam logic [3:0]  BOOT_ADDR_LAST = 4'h3;
  localparam logic [3:0]  SAVE_LAST      = 4'hF;
  // answer lengths in bytes
  localparam logic [2:0] LEN_NONE        = 3'h0;
  localparam logic [2:0] LEN_BYTE        = 3'h1;
  localparam logic [2:0] LEN_WORD        = 3'h2;
  localparam logic [2:0] LEN_BLOCK       = 3'h5;
  // values after reset
  localparam logic [5:0]  RST_PHASES     = 6'h01;
  localparam logic [1:0]  RST_FMT        = 2'h0;
  localparam logic [11:0] RST_VOUT       = 12'h000;
  localparam logic [11:0] RST_VOUT_UPPER_LIMIT   = 12'hFFF;
  localparam logic [10:0] RST_DIV        = 11'h400;
  localparam logic [6:0]  RST_LOCK       = 7'h00;
  localparam logic [8:0]  RST_OFFSET     = 9'h000;
  localparam logic [9:0]  RST_OC         = 10'h3FF;
  localparam logic [9:0]  RST_BOOT       = 10'h000;
  localparam logic [7:0]  RST_OT         = 8'hFF;

  typedef enum logic {PCL_IDLE, PCL_SAVE} pcl_save_state_t;
endpackage

/* tb/pcl_host_model.sv */
// host model that issues one-cycle register requests to the bank
`timescale 1ns/10ps
`default_nettype none
module pcl_host_model (
  // clock
  input  wire logic        i_clock,
  // request strobe and qualifiers
  output logic             o_valid,
  output logic             o_write,
  output logic [7:0]       o_code,
  output logic [15:0]      o_data
);
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code  = 8'h00;
    o_data  = 16'h0000;
  end
  // held over one rising edge, then the lines stop showing the old request
  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(negedge i_clock);
    o_valid = 1'b1;
    o_write = wr;
    o_code  = code;
    o_data  = data;
    @(negedge i_clock);
    o_valid = 1'b0;
    o_write = ~wr;
    o_code  = ~code;
    o_data  = ~data;
  endtask
endmodule
`default_nettype wire

/* tb/pcl_config_regs_tb.sv */
// self-checking bench for the configuration and limit register bank
`timescale 1ns/10ps
`default_nettype none
module pcl_config_regs_tb
  import pcl_pkg::*;
;
  typedef struct packed {logic [7:0] c; logic [15:0] w; logic [15:0] r; logic [2:0] n;} pcl_row_t;
  logic        clock, rstn, valid, wr, a7, c4, store, ack, nack, clamped, lin, shed, vb_act, nv_v;
  logic        busy;
  logic [6:0]  lrise, lfall;
  logic [10:0] div;
  logic [1:0]  src;
  logic [3:0]  alow;
  logic [5:0]  act, target;
  logic [7:0]  code, nv_code, otf, otw;
  logic [15:0] wdata, raw, irep, nv_data, ds;
  logic [39:0] rdata;
  logic [2:0]  rlen;
  logic [11:0] vref;
  logic [9:0]  vboot, ocf, ocw;
  int          failures, n_checks, cyc, nw, bad, nb;
  logic [11:0] ref_exp [3] = '{12'h100, 12'h080, 12'h180};
  logic [7:0]  refused [3] = '{8'h19, 8'h30, 8'h22};
  pcl_row_t    rows [22] = '{
    '{8'h1C, 16'hFFFF, 16'h003F, 3'h1}, '{8'h20, 16'h0000, 16'h0017, 3'h1},
    '{8'h20, 16'h0020, 16'h0020, 3'h1}, '{8'h20, 16'h0040, 16'h0040, 3'h1},
    '{8'h20, 16'hFFFF, 16'h0060, 3'h1}, '{8'h21, 16'hFFFF, 16'h0FFF, 3'h2},
    '{8'h24, 16'hFFFF, 16'h0FFF, 3'h2}, '{8'h25, 16'hFFFF, 16'h0FFF, 3'h2},
    '{8'h26, 16'hFFFF, 16'h0FFF, 3'h2}, '{8'h29, 16'hFFFF, 16'h07FF, 3'h2},
    '{8'h2B, 16'hFFFF, 16'h0FFF, 3'h2}, '{8'h35, 16'hFFFF, 16'h007F, 3'h2},
    '{8'h36, 16'hFFFF, 16'h007F, 3'h2}, '{8'h38, 16'hFFFF, 16'h0400, 3'h2},
    '{8'h39, 16'hFFFF, 16'h01FF, 3'h2}, '{8'h46, 16'hFFFF, 16'h03FF, 3'h2},
    '{8'h4A, 16'hFFFF, 16'h03FF, 3'h2}, '{8'h4D, 16'hFFFF, 16'h03FF, 3'h2},
    '{8'h4F, 16'hFFFF, 16'h00FF, 3'h2}, '{8'h51, 16'hFFFF, 16'h00FF, 3'h2},
    '{8'h19, 16'h0000, 16'h00B0, 3'h1}, '{8'h1C, 16'h0002, 16'h0002, 3'h1}};
  pcl_host_model i_pcl_host_model (.i_clock(clock), .o_valid(valid), .o_write(wr),
    .o_code(code), .o_data(wdata));
  pcl_config_regs i_pcl_config_regs (.I_CLOCK(clock), .I_RSTN(rstn), .I_REQ_VALID(valid),
    .I_REQ_WRITE(wr), .I_REQ_CODE(code), .I_REQ_DATA(wdata), .O_ACK(ack), .O_NACK(nack),
    .O_RD_DATA(rdata), .O_RD_LEN(rlen), .I_REF_SOURCE(src), .O_VREF_CODE(vref),
    .O_VREF_CLAMPED(clamped), .O_FMT_LINEAR(lin), .I_ACTIVE_PHASES(act),
    .O_PHASE_TARGET(target), .O_PHASE_SHED(shed), .O_DIVIDER_RATIO(div),
    .O_LOCKOUT_RISE(lrise), .O_LOCKOUT_FALL(lfall), .O_OC_FAULT_LIMIT(ocf),
    .O_OC_WARN_LIMIT(ocw), .O_OVERTEMP_FAULT_LIMIT(otf), .O_OVERTEMP_WARN_LIMIT(otw),
    .I_IOUT_RAW(raw), .O_IOUT_REPORT(irep), .I_BUS_ADDR_LOW(alow),
    .I_ADDR_CFG_BIT7(a7), .I_CFG_BIT4(c4), .O_VBOOT_CODE(vboot), .O_VBOOT_ACTIVE(vb_act),
    .I_STORE_ALL(store), .O_NVM_BUSY(busy), .O_NVM_WR_VALID(nv_v), .O_NVM_WR_CODE(nv_code),
    .O_NVM_WR_DATA(nv_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, a7, store, src, nw, bad, ds} = '0;
    {act, alow, c4, raw} = {6'h04, 4'h2, 1'b1, 16'h0010};
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    check({target, lin}, {6'h01, 1'b1});
    foreach (refused[i]) begin
      i_pcl_host_model.send(1'b1, refused[i], 16'hFFFF);
      check({ack, nack, rlen, rdata}, {2'b01, 3'h0, 40'h0});
    end
    i_pcl_host_model.send(1'b0, 8'h30, 16'h0000);
    check({ack, nack, rlen, rdata}, {2'b10, 3'h5, 40'h01_0000_0040});
    foreach (rows[i]) begin
      if (rows[i].c != 8'h19) i_pcl_host_model.send(1'b1, rows[i].c, rows[i].w);
      i_pcl_host_model.send(1'b0, rows[i].c, 16'h0000);
      check({ack, nack, rlen, rdata}, {2'b10, rows[i].n, 24'h0, rows[i].r});
    end
    @(negedge clock);
    check({shed, target, lin}, {1'b1, 6'h02, 1'b0});
    check({div, lrise, lfall, ocf, ocw, otf, otw},
          {11'h7FF, 7'h7F, 7'h7F, 10'h3FF, 10'h3FF, 8'hFF, 8'hFF});
    check(irep, 16'h000F);
    check({vb_act, vboot}, {1'b1, 10'h3FF});
    a7 = 1'b1;
    repeat (2) @(negedge clock);
    check({vb_act, vboot}, {1'b0, 10'h000});
    i_pcl_host_model.send(1'b1, 8'h21, 16'h0100);
    i_pcl_host_model.send(1'b1, 8'h25, 16'h0200);
    i_pcl_host_model.send(1'b1, 8'h26, 16'h0050);
    i_pcl_host_model.send(1'b1, 8'h24, 16'h0180);
    i_pcl_host_model.send(1'b1, 8'h2B, 16'h0080);
    for (int s = 0; s < 3; s++) begin
      src = 2'(s);
      repeat (3) @(negedge clock);
      check({clamped, vref}, {s != 0, ref_exp[s]});
    end
    store = 1'b1;
    @(negedge clock);
    store = 1'b0;
    repeat (20) begin
      @(posedge clock);
      #1;
      nw += int'(nv_v === 1'b1);
      bad += int'(nv_v === 1'b1 && nv_code === 8'h1C);
      nb += int'(busy === 1'b1);
      ds += nv_v ? nv_data : 16'h0000;
    end
    check({bad[7:0], nw[7:0], nb[7:0], ds}, {8'h00, 8'h10, 8'h0F, 16'h22A7});
    // margin low inside the limits, then the unsupported source holds the reference
    i_pcl_host_model.send(1'b1, 8'h2B, 16'h0040);
    src = 2'h1;
    repeat (3) @(negedge clock);
    check({clamped, vref}, {1'b0, 12'h050});
    src = 2'h3;
    i_pcl_host_model.send(1'b1, 8'h26, 16'h0060);
    repeat (3) @(negedge clock);
    check({clamped, vref}, {1'b0, 12'h050});
    tally_and_finish();
  end
endmodule
`default_nettype wire
